// File: hdl/dgp_pkg.sv
// Purpose: Shared constants and types for the dual general-purpose port block
// Assumes: APB with 32-bit data, each register one aligned word
// Notes:   Printed offsets are not all multiples of four, so they are indices
`default_nettype none
package dgp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] DGP_IDX_ACT    = 8'h30;
    localparam logic [7:0] DGP_IDX_P1_DIR = 8'hE0;
    localparam logic [7:0] DGP_IDX_P1_VAL = 8'hE1;
    localparam logic [7:0] DGP_IDX_P1_POL = 8'hE2;
    localparam logic [7:0] DGP_IDX_P1_EVT = 8'hE3;
    localparam logic [7:0] DGP_IDX_P2_DIR = 8'hE4;
    localparam logic [7:0] DGP_IDX_P2_VAL = 8'hE5;
    localparam logic [7:0] DGP_IDX_P2_POL = 8'hE6;
    localparam logic [7:0] DGP_IDX_P2_EVT = 8'hE7;
    localparam logic [7:0] DGP_IDX_IRQ_STA = 8'hF0;
    localparam logic [7:0] DGP_IDX_IRQ_EN  = 8'hF1;
    localparam logic [7:0] DGP_IDX_IRQ_CLR = 8'hF2;

    // Reset values
    localparam logic [1:0] DGP_RST_ACT = 2'h3;
    localparam logic [7:0] DGP_RST_DIR = 8'hFF;
    localparam logic [7:0] DGP_RST_VAL = 8'h00;
    localparam logic [7:0] DGP_RST_POL = 8'h00;
    localparam logic [7:0] DGP_RST_EVT = 8'h00;
    localparam logic [1:0] DGP_RST_IRQ = 2'h0;

    // Field positions
    localparam int DGP_ACT_P1_BIT  = 0;
    localparam int DGP_ACT_P2_BIT  = 1;
    localparam int DGP_P2_EVT_BITS = 5;

    // Per-port configuration carrier
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] val;
        logic [7:0] pol;
    } dgp_cfg_t;

    typedef enum logic [1:0] {
        DGP_APB_IDLE,
        DGP_APB_ACCESS
    } dgp_apb_state_t;
endpackage : dgp_pkg
`default_nettype wire

// File: hdl/dgp_port.sv
// Purpose: One eight-pin port: pad driving, input sync, edge flags
// Assumes: Pins asynchronous to pclk
// Notes:   Flags only exist for bits below EVT_BITS
`default_nettype none
module dgp_port
    import dgp_pkg::*;
#(
    parameter int EVT_BITS = 8
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Configuration
    input  wire logic       active,
    input  wire dgp_cfg_t   cfg,
    input  wire logic       rd_clear,
    // Pins
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    // Status
    output logic      [7:0] pin_level,
    output logic      [7:0] evt_flags,
    output logic            evt_new
);
    logic [7:0] sync1_q, sync1_d;
    logic [7:0] sync2_q, sync2_d;
    logic [7:0] prev_q,  prev_d;
    logic [7:0] evt_q,   evt_d;
    logic [7:0] out_q,   out_d;
    logic [7:0] oe_q,    oe_d;
    logic       new_q,   new_d;
    logic [2:0] prime_q, prime_d;
    logic [7:0] edges;
    logic [7:0] evt_mask;

    always_comb begin
        evt_mask = 8'hFF >> (8 - EVT_BITS);
        sync1_d  = pin_in;
        sync2_d  = sync1_q;
        prev_d   = sync2_q;
        prime_d  = {prime_q[1:0], 1'b1};
        edges    = (sync2_q ^ prev_q) & evt_mask;
        if (!active) begin
            edges = 8'h00;
        end
        // Pins have no idle level; no edges until the chain holds real levels
        if (!prime_q[2]) begin
            edges = 8'h00;
        end
        // Set beats clear so no edge is lost
        evt_d    = (rd_clear ? 8'h00 : evt_q) | edges;
        new_d    = |edges;
        out_d    = cfg.val ^ cfg.pol;
        oe_d     = active ? ~cfg.dir : 8'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q  <= 8'h00;
            evt_q   <= DGP_RST_EVT;
            out_q   <= 8'h00;
            oe_q    <= 8'h00;
            new_q   <= 1'b0;
            prime_q <= 3'h0;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            prev_q  <= prev_d;
            evt_q   <= evt_d;
            out_q   <= out_d;
            oe_q    <= oe_d;
            new_q   <= new_d;
            prime_q <= prime_d;
        end
    end

    assign pin_out   = out_q;
    assign pin_oe    = oe_q;
    assign pin_level = sync2_q ^ cfg.pol;
    assign evt_flags = evt_q;
    assign evt_new   = new_q;
endmodule : dgp_port
`default_nettype wire

// File: hdl/dgp_top.sv
// Purpose: Dual general-purpose port block behind an APB slave
// Assumes: 40 MHz pclk, pins asynchronous, APB master keeps protocol
// Notes:   One-wait-state APB; unmapped reads give zero, PSLVERR stays low
//
// Functional notes
// - Activation bit 0 enables first port, bit 1 second; both active after reset.
// - Direction bit 0 makes the pin an output, 1 an input; reset all inputs.
// - Output pins take written data bits and read them back; reset zero.
// - Input pins read the pin level; writes leave those bits unchanged.
// - Polarity bit 1 inverts between data bit and pin, both directions.
// - A rising or falling edge on a pin sets its port's flag.
// - First port flags 7..0 map to its pins 7..0.
// - Second port flags exist only in bits 4..0, mapping to pins 4..0.
// - Reading a flag register returns flags then clears them; writes ignored.
//
// The APB register port was chosen for this implementation.
`default_nettype none
module dgp_top
    import dgp_pkg::*;
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB request
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    // APB answer
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // First port pins
    input  wire logic [7:0]  first_port_pins_in,
    output logic      [7:0]  first_port_pins_out,
    output logic      [7:0]  first_port_pins_oe,
    // Second port pins
    input  wire logic [7:0]  second_port_pins_in,
    output logic      [7:0]  second_port_pins_out,
    output logic      [7:0]  second_port_pins_oe,
    // Interrupt
    output logic             irq
);
    logic [1:0]  act_q,    act_d;
    dgp_cfg_t    p1_q,     p1_d;
    dgp_cfg_t    p2_q,     p2_d;
    logic [1:0]  ista_q,   ista_d;
    logic [1:0]  ien_q,    ien_d;
    logic        irq_q,    irq_d;
    logic [31:0] rdata_q,  rdata_d;
    logic        ready_q,  ready_d;
    dgp_apb_state_t st_q,  st_d;
    logic        clr1,     clr2;
    logic [7:0]  lvl1,     lvl2;
    logic [7:0]  flg1,     flg2;
    logic        new1,     new2;
    logic [7:0]  idx;
    logic        wr_en,    rd_en;
    logic [7:0]  wb;

    assign idx   = paddr[9:2];
    assign wb    = pwdata[7:0];
    // Access accepted in the first access cycle; pready pulses in the second
    assign wr_en = psel && penable && !ready_q && pwrite;
    assign rd_en = psel && penable && !ready_q && !pwrite;

    // APB handshake
    always_comb begin
        st_d    = st_q;
        ready_d = 1'b0;
        case (st_q)
            DGP_APB_IDLE: begin
                if (psel && !penable) begin
                    st_d = DGP_APB_ACCESS;
                end
            end
            DGP_APB_ACCESS: begin
                if (psel && penable && !ready_q) begin
                    ready_d = 1'b1;
                end else if (ready_q) begin
                    st_d = DGP_APB_IDLE;
                end
            end
            default: begin
                st_d = DGP_APB_IDLE;
            end
        endcase
    end

    // Configuration writes
    always_comb begin
        act_d = act_q;
        p1_d  = p1_q;
        p2_d  = p2_q;
        ien_d = ien_q;
        if (wr_en) begin
            if (idx == DGP_IDX_ACT) begin
                act_d = wb[1:0];
            end else if (idx == DGP_IDX_P1_DIR) begin
                p1_d.dir = wb;
            end else if (idx == DGP_IDX_P1_VAL) begin
                p1_d.val = (wb & ~p1_q.dir) | (p1_q.val & p1_q.dir);
            end else if (idx == DGP_IDX_P1_POL) begin
                p1_d.pol = wb;
            end else if (idx == DGP_IDX_P2_DIR) begin
                p2_d.dir = wb;
            end else if (idx == DGP_IDX_P2_VAL) begin
                p2_d.val = (wb & ~p2_q.dir) | (p2_q.val & p2_q.dir);
            end else if (idx == DGP_IDX_P2_POL) begin
                p2_d.pol = wb;
            end else if (idx == DGP_IDX_IRQ_EN) begin
                ien_d = wb[1:0];
            end
        end
    end

    // Read clears of the flag registers
    assign clr1 = rd_en && (idx == DGP_IDX_P1_EVT);
    assign clr2 = rd_en && (idx == DGP_IDX_P2_EVT);

    // Read data
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rd_en) begin
            if (idx == DGP_IDX_ACT) begin
                rdata_d[1:0] = act_q;
            end else if (idx == DGP_IDX_P1_DIR) begin
                rdata_d[7:0] = p1_q.dir;
            end else if (idx == DGP_IDX_P1_VAL) begin
                rdata_d[7:0] = (p1_q.val & ~p1_q.dir) | (lvl1 & p1_q.dir);
            end else if (idx == DGP_IDX_P1_POL) begin
                rdata_d[7:0] = p1_q.pol;
            end else if (idx == DGP_IDX_P1_EVT) begin
                rdata_d[7:0] = flg1;
            end else if (idx == DGP_IDX_P2_DIR) begin
                rdata_d[7:0] = p2_q.dir;
            end else if (idx == DGP_IDX_P2_VAL) begin
                rdata_d[7:0] = (p2_q.val & ~p2_q.dir) | (lvl2 & p2_q.dir);
            end else if (idx == DGP_IDX_P2_POL) begin
                rdata_d[7:0] = p2_q.pol;
            end else if (idx == DGP_IDX_P2_EVT) begin
                rdata_d[7:0] = flg2;
            end else if (idx == DGP_IDX_IRQ_STA) begin
                rdata_d[1:0] = ista_q;
            end else if (idx == DGP_IDX_IRQ_EN) begin
                rdata_d[1:0] = ien_q;
            end
        end else begin
            rdata_d = rdata_q;
        end
    end

    // Sticky interrupt status: new edge beats write-one clear
    always_comb begin
        ista_d = ista_q;
        if (wr_en && idx == DGP_IDX_IRQ_CLR) begin
            ista_d = ista_q & ~wb[1:0];
        end
        ista_d = ista_d | {new2, new1};
        irq_d  = |(ista_d & ien_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q   <= DGP_RST_ACT;
            p1_q    <= '{dir: DGP_RST_DIR, val: DGP_RST_VAL, pol: DGP_RST_POL};
            p2_q    <= '{dir: DGP_RST_DIR, val: DGP_RST_VAL, pol: DGP_RST_POL};
            ista_q  <= DGP_RST_IRQ;
            ien_q   <= DGP_RST_IRQ;
            irq_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            st_q    <= DGP_APB_IDLE;
        end else begin
            act_q   <= act_d;
            p1_q    <= p1_d;
            p2_q    <= p2_d;
            ista_q  <= ista_d;
            ien_q   <= ien_d;
            irq_q   <= irq_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            st_q    <= st_d;
        end
    end

    dgp_port #(
        .EVT_BITS (8)
    ) u_first_gp_port (
        .pclk      (pclk),
        .presetn   (presetn),
        .active    (act_q[DGP_ACT_P1_BIT]),
        .cfg       (p1_q),
        .rd_clear  (clr1),
        .pin_in    (first_port_pins_in),
        .pin_out   (first_port_pins_out),
        .pin_oe    (first_port_pins_oe),
        .pin_level (lvl1),
        .evt_flags (flg1),
        .evt_new   (new1)
    );

    dgp_port #(
        .EVT_BITS (DGP_P2_EVT_BITS)
    ) u_second_gp_port (
        .pclk      (pclk),
        .presetn   (presetn),
        .active    (act_q[DGP_ACT_P2_BIT]),
        .cfg       (p2_q),
        .rd_clear  (clr2),
        .pin_in    (second_port_pins_in),
        .pin_out   (second_port_pins_out),
        .pin_oe    (second_port_pins_oe),
        .pin_level (lvl2),
        .evt_flags (flg2),
        .evt_new   (new2)
    );

    assign prdata  = rdata_q;
    assign pready  = ready_q;
    assign pslverr = 1'b0;
    assign irq     = irq_q;
endmodule : dgp_top
`default_nettype wire

// File: test/dgp_sva.sv
// Purpose: Port-level checks for the dual port block
// Assumes: One pclk domain, async active-low presetn
// Notes:   Bound from the bench top file
`default_nettype none
module dgp_sva
    import dgp_pkg::*;
(
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic [7:0]  first_port_pins_out,
    input wire logic [7:0]  first_port_pins_oe,
    input wire logic [7:0]  second_port_pins_out,
    input wire logic [7:0]  second_port_pins_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;
    a_ready_after: assert property (acc && !pready |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_ready_cause: assert property (pready |-> acc && $past(acc))
        else $error("pready outside access");
    a_err_low: assert property (!pslverr)
        else $error("pslverr raised");
    // Pin drive moves only after a register write
    a_pins_hold: assert property (!(acc && pwrite) |=>
        $stable({first_port_pins_out, first_port_pins_oe, second_port_pins_out, second_port_pins_oe}))
        else $error("pin drive moved");
    a_rdata_moves: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("prdata moved");
    a_p2_width: assert property (pready && !pwrite && paddr[9:2] == DGP_IDX_P2_EVT |->
        prdata[31:5] == 27'h0)
        else $error("second flags too wide");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule : dgp_sva
`default_nettype wire

// File: test/dgp_pin_model.sv
// Purpose: Far-side model of one port's pins
// Assumes: No pull on pins, outside source always drives
// Notes:   Block drive wins where its enable is high
`default_nettype none
module dgp_pin_model (
    // Block side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // Outside source
    input  wire logic [7:0] ext,
    output logic      [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : dgp_pin_model
`default_nettype wire

// File: test/tb_dgp_top.sv
// Purpose: Self-checking bench for the dual port block
// Assumes: APB master leaves one idle cycle between transfers
// Notes:   Expected read results are queued, a monitor compares them
`default_nettype none
module tb_dgp_top
    import dgp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, exp_v;
    logic        pready, pslverr, irq;
    logic [7:0]  p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe, r, p, t;
    logic [7:0]  ext1 = 8'h00, ext2 = 8'h00;
    logic [31:0] exp_q[$];
    int          errors = 0, n_tests = 0;
    logic [7:0]  ri[12] = '{DGP_IDX_ACT, DGP_IDX_P1_DIR, DGP_IDX_P1_VAL, DGP_IDX_P1_POL, DGP_IDX_P1_EVT,
        DGP_IDX_P2_DIR, DGP_IDX_P2_VAL, DGP_IDX_P2_POL, DGP_IDX_P2_EVT, DGP_IDX_IRQ_STA, DGP_IDX_IRQ_EN, 8'h10};
    logic [31:0] rv[12] = '{32'h3, 32'hFF, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    always #12.5 pclk = ~pclk;
    dgp_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .first_port_pins_in(p1_in), .first_port_pins_out(p1_out), .first_port_pins_oe(p1_oe),
        .second_port_pins_in(p2_in), .second_port_pins_out(p2_out), .second_port_pins_oe(p2_oe), .irq);
    dgp_pin_model u_m1 (.pin_out(p1_out), .pin_oe(p1_oe), .ext(ext1), .pin_in(p1_in));
    dgp_pin_model u_m2 (.pin_out(p2_out), .pin_oe(p2_oe), .ext(ext2), .pin_in(p2_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            errors++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic acc(input logic [7:0] idx, input logic w, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : acc
    task automatic rd(input logic [7:0] idx, input logic [31:0] want);
        exp_q.push_back(want);
        acc(idx, 1'b0, 8'h00);
    endtask : rd
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Read data first stands in the pready cycle, held until the next read
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1 && !pwrite) begin
            exp_v = exp_q.pop_front();
            chk(prdata, exp_v);
        end
    end
    initial begin
        #75000;
        errors++;
        finish_test();
    end
    initial begin
        void'($urandom(14861));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        acc(8'h10, 1'b1, 8'hFF);
        foreach (ri[i]) rd(ri[i], rv[i]);
        r = 8'($urandom);
        p = 8'($urandom);
        acc(DGP_IDX_P1_DIR, 1'b1, 8'h0F);
        acc(DGP_IDX_P1_VAL, 1'b1, r);
        acc(DGP_IDX_P1_POL, 1'b1, p);
        repeat (2) @(negedge pclk);
        chk(32'(p1_oe), 32'hF0);
        chk(32'(p1_out & 8'hF0), 32'((r ^ p) & 8'hF0));
        rd(DGP_IDX_P1_VAL, 32'((r & 8'hF0) | (p & 8'h0F)));
        acc(DGP_IDX_P1_EVT, 1'b1, 8'hFF);
        rd(DGP_IDX_P1_EVT, 32'((r | p) & 8'hF0));
        rd(DGP_IDX_P1_EVT, 32'h0);
        acc(DGP_IDX_P1_DIR, 1'b1, 8'h00);
        rd(DGP_IDX_P1_VAL, 32'(r & 8'hF0));
        acc(DGP_IDX_P1_DIR, 1'b1, 8'h0F);
        t = 8'($urandom) | 8'h01;
        @(posedge pclk);
        ext1 <= t;
        ext2 <= t;
        repeat (5) @(negedge pclk);
        rd(DGP_IDX_P1_EVT, 32'((t | p) & 8'h0F));
        // Edge lands on the clearing edge of the read: read sees 0, flag survives
        @(posedge pclk);
        ext1 <= t ^ 8'h01;
        rd(DGP_IDX_P1_EVT, 32'h0);
        rd(DGP_IDX_P1_EVT, 32'h1);
        rd(DGP_IDX_P2_EVT, 32'(t & 8'h1F));
        rd(DGP_IDX_P2_VAL, 32'(t));
        acc(DGP_IDX_P2_POL, 1'b1, p);
        rd(DGP_IDX_P2_VAL, 32'(t ^ p));
        rd(DGP_IDX_IRQ_STA, 32'h3);
        chk(32'(irq), 32'h0);
        acc(DGP_IDX_IRQ_EN, 1'b1, 8'h01);
        repeat (2) @(negedge pclk);
        chk(32'(irq), 32'h1);
        acc(DGP_IDX_IRQ_CLR, 1'b1, 8'h01);
        repeat (2) @(negedge pclk);
        chk(32'(irq), 32'h0);
        rd(DGP_IDX_IRQ_STA, 32'h2);
        acc(DGP_IDX_P2_DIR, 1'b1, 8'h00);
        acc(DGP_IDX_P2_VAL, 1'b1, r);
        repeat (2) @(negedge pclk);
        chk(32'({p2_oe, p2_out}), 32'({8'hFF, r ^ p}));
        rd(DGP_IDX_P2_VAL, 32'(r));
        acc(DGP_IDX_ACT, 1'b1, 8'h02);
        @(posedge pclk);
        ext1 <= ~t;
        repeat (5) @(negedge pclk);
        chk(32'(p1_oe), 32'h0);
        rd(DGP_IDX_P1_EVT, 32'h0);
        rd(DGP_IDX_ACT, 32'h2);
        finish_test();
    end
endmodule : tb_dgp_top
bind dgp_top dgp_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .first_port_pins_out, .first_port_pins_oe, .second_port_pins_out, .second_port_pins_oe);
`default_nettype wire
